// ### irtm_pkg.sv
// Purpose: Shared constants for both thermometer ends.
// Assumes: 10 MHz system clock on both ends.
// Notes:   Temperatures are 16-bit Kelvin codes at 0.02 K per step.
`default_nettype none
package irtm_pkg;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          REQ_TIME_NS    = 1440000;
    localparam int          REQ_CYC        = REQ_TIME_NS / CLK_PERIOD_NS;
    localparam int          REQ_MARGIN_CYC = 200;
    localparam int          REQ_HOLD_CYC   = REQ_CYC + REQ_MARGIN_CYC;
    localparam int          K_PER_DEG_DIV  = 50;
    localparam logic [15:0] TA_LIN_MIN     = 16'h2de4;
    localparam logic [15:0] TA_LIN_MAX     = 16'h4dc4;
    localparam logic [15:0] TO_MAX_VALID   = 16'h7fff;
    localparam logic [15:0] HYST_MIN       = 16'h0001;
    localparam logic [7:0]  CELL_IR1       = 8'h04;
    localparam logic [7:0]  CELL_IR2       = 8'h05;
    localparam logic [7:0]  CELL_TA        = 8'h06;
    localparam logic [7:0]  CELL_TO1       = 8'h07;
    localparam logic [7:0]  CELL_TO2       = 8'h08;
    localparam logic [7:0]  NV_PWM_CTRL    = 8'h02;
    localparam logic [7:0]  NV_HYST        = 8'h20;
    localparam logic [7:0]  NV_THRESH      = 8'h21;
    localparam int          PWM_WORD_W     = 10;
    localparam int          PWM_SHIFT      = 6;
    localparam logic [3:0]  HOST_CTRL_ADDR = 4'h0;
    localparam logic [3:0]  HOST_STAT_ADDR = 4'h4;
    localparam int          CTRL_GO_BIT    = 0;
    localparam int          CTRL_PWMEN_BIT = 1;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_DONE_BIT  = 1;
    localparam int          STAT_SDA_BIT   = 2;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : irtm_pkg
`default_nettype wire

// ### irtm_link_if.sv
// Purpose: Two-wire link between the thermometer end and the host end.
// Assumes: Both lines are pulled high when nobody drives them.
// Notes:   Resolved levels follow the enables.
`default_nettype none
interface irtm_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
    logic scl;
    logic sda;

    assign scl = scl_oe ? scl_out : 1'b1;
    assign sda = sda_oe ? sda_out : 1'b1;

    modport dev (input scl, input sda, output sda_out, output sda_oe);
    modport host (input scl, input sda, output scl_out, output scl_oe);
endinterface : irtm_link_if
`default_nettype wire

// ### irtm_device.sv
// Purpose: Thermometer end: measurement loop, relay comparator, shared pin.
// Assumes: Raw results and stored settings arrive on plain ports.
// Notes:   In bus mode the pin is released; the serial slave lives elsewhere.
`default_nettype none
// Operation
// R01 - Host keeps clock high during pulse output.
// R02 - Clock low past request time selects bus.
// R03 - Data level ignored during request detection.
// R04 - Output returns only after power or wake.
// R05 - Output disabled setting means bus from reset.
// R06 - Host sends no request when output disabled.
// R07 - Ambient result in cell 6, clamped range.
// R08 - Results are unsigned Kelvin, fifty per degree.
// R09 - Object MSB is error; max valid 0x7fff.
// R10 - Load settings after reset, then loop forever.
// R11 - Ambient stores offset, value, then temperature.
// R12 - Sensor one reading cell 4, temperature 7.
// R13 - Sensor two cells 5, 8; skipped single.
// R14 - Pass ends loading 10-bit output word.
// R15 - Filters share one stored length setting.
// R16 - Relay needs relay bit and output enable.
// R17 - Relay compares object one via output driver.
// R18 - Drive type picks push-pull or open-drain.
// R19 - Threshold and hysteresis from stored cells.
// R20 - High at upper point, low at lower.
// R21 - Between switching points the level holds.
// R22 - Threshold Kelvin hundredths; hysteresis at least one; the code compares the threshold unscaled with the 0.02 K object code.
// R23 - Relay mode readable; resumes only after reset; the code also resumes it on wake.
module irtm_device
    import irtm_pkg::*;
#(
    parameter int P_REQ_CYC = REQ_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    irtm_link_if.dev         link,
    input  wire logic        i_sleep_exit,
    input  wire logic        i_pwm_enable,
    input  wire logic        i_relay_select,
    input  wire logic        i_drive_open_drain,
    input  wire logic        i_dual_ir,
    input  wire logic [2:0]  i_iir_len,
    input  wire logic [15:0] i_relay_threshold,
    input  wire logic [15:0] i_relay_hysteresis,
    input  wire logic [15:0] i_pwm_min,
    input  wire logic [15:0] i_ta_offset_raw,
    input  wire logic [15:0] i_ta_raw,
    input  wire logic [15:0] i_ir1_raw,
    input  wire logic [15:0] i_ir2_raw,
    input  wire logic        i_obj_error,
    output logic      [15:0] o_ambient_sensor_offset,
    output logic      [15:0] o_ambient_sensor_value,
    output logic      [15:0] o_ambient_temperature,
    output logic      [15:0] o_ir1_filtered_reading,
    output logic      [15:0] o_ir2_filtered_reading,
    output logic      [15:0] o_object_temperature_one,
    output logic      [15:0] o_object_temperature_two,
    output logic      [9:0]  o_pwm_word,
    output logic             o_smbus_mode,
    output logic             o_relay_level
);
    initial begin
        if (P_REQ_CYC < 1 || P_REQ_CYC > 65534) begin
            $error("P_REQ_CYC out of range");
        end
    end

    typedef enum {
        S_INIT, S_TA_OFS, S_TA_VAL, S_TA, S_IR1_D, S_TO1, S_IR2_D, S_TO2, S_PWM
    } irtm_state_e;

    function automatic logic [15:0] iir_step(input logic [15:0] f, input logic [15:0] x,
                                             input logic [2:0] len);
        logic signed [16:0] d;
        d = $signed({1'b0, x}) - $signed({1'b0, f});
        return 16'(f + 16'(d >>> len));
    endfunction : iir_step

    function automatic logic [15:0] obj_code(input logic [15:0] ta, input logic [15:0] ir,
                                             input logic err);
        logic [16:0] s;
        s = {1'b0, ta} + {1'b0, ir};
        if (err) begin
            return {1'b1, s[14:0]};
        end
        return (s > {1'b0, TO_MAX_VALID}) ? TO_MAX_VALID : s[15:0];
    endfunction : obj_code

    irtm_state_e state_reg;
    irtm_state_e state_next;
    logic        scl_s1_reg;
    logic        scl_s2_reg;
    logic [15:0] low_cnt_reg;
    logic        out_off_reg;
    logic        dual_reg;
    logic [2:0]  len_reg;
    logic [9:0]  pwm_cnt_reg;
    logic        relay_reg;
    logic        sda_out_reg;
    logic        sda_oe_reg;

    wire         req_seen  = !scl_s2_reg && (low_cnt_reg > 16'(P_REQ_CYC));
    wire         out_mode  = i_pwm_enable && !out_off_reg;
    wire         relay_on  = out_mode && i_relay_select;
    wire  [15:0] hyst_eff  = (i_relay_hysteresis < HYST_MIN) ? HYST_MIN : i_relay_hysteresis;
    wire  [16:0] up_eff    = {1'b0, i_relay_threshold} + {1'b0, hyst_eff};
    wire  [16:0] lo_point  = {1'b0, i_relay_threshold} - {1'b0, hyst_eff};
    wire         lo_valid  = !lo_point[16];
    wire  [15:0] to1       = o_object_temperature_one;
    wire         go_high   = {1'b0, to1} >= up_eff;
    wire         go_low    = lo_valid && ({1'b0, to1} <= lo_point);
    wire  [16:0] pwm_diff  = {1'b0, to1} - {1'b0, i_pwm_min};
    wire  [9:0]  pwm_calc  = pwm_diff[16] ? 10'h000 : pwm_diff[15:6];
    wire  [15:0] ta_comp   = o_ambient_sensor_value - o_ambient_sensor_offset;
    wire  [15:0] ta_clamp  = (ta_comp < TA_LIN_MIN) ? TA_LIN_MIN :
                             (ta_comp > TA_LIN_MAX) ? TA_LIN_MAX : ta_comp;
    wire         pin_level = relay_on ? relay_reg : (pwm_cnt_reg < o_pwm_word);

    // Two flip-flops synchronise the link clock.
    always_ff @(posedge i_clk) begin
        scl_s1_reg <= link.scl;
        scl_s2_reg <= scl_s1_reg;
    end

    // Only the clock line is timed. [R03]
    always_ff @(posedge i_clk) begin
        if (i_rst || scl_s2_reg) begin
            low_cnt_reg <= 16'h0000;
        end else if (low_cnt_reg != 16'hffff) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end

    // A request turns the output off until reset or wake. [R02] [R04] [R23]
    always_ff @(posedge i_clk) begin
        if (i_rst || i_sleep_exit) begin
            out_off_reg <= 1'b0;
        end else if (i_pwm_enable && req_seen) begin
            out_off_reg <= 1'b1;
        end
    end

    always_comb begin
        unique case (state_reg)
            S_INIT:   state_next = S_TA_OFS;
            S_TA_OFS: state_next = S_TA_VAL;
            S_TA_VAL: state_next = S_TA;
            S_TA:     state_next = S_IR1_D;
            S_IR1_D:  state_next = S_TO1;
            S_TO1:    state_next = dual_reg ? S_IR2_D : S_PWM; // [R13]
            S_IR2_D:  state_next = S_TO2;
            S_TO2:    state_next = S_PWM;
            S_PWM:    state_next = S_TA_OFS; // [R10]
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= S_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sensor count and filter length are taken once. [R10] [R15]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dual_reg <= 1'b0;
            len_reg  <= 3'h0;
        end else if (state_reg == S_INIT) begin
            dual_reg <= i_dual_ir;
            len_reg  <= i_iir_len;
        end
    end

    // Kelvin codes at 0.02 K per step. [R08]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ambient_sensor_offset  <= 16'h0000;
            o_ambient_sensor_value   <= 16'h0000;
            o_ambient_temperature    <= TA_LIN_MIN;
            o_ir1_filtered_reading   <= 16'h0000;
            o_ir2_filtered_reading   <= 16'h0000;
            o_object_temperature_one <= 16'h0000;
            o_object_temperature_two <= 16'h0000;
            o_pwm_word               <= 10'h000;
        end else begin
            unique case (state_reg)
                S_INIT:   ;
                S_TA_OFS: o_ambient_sensor_offset <= i_ta_offset_raw; // [R11]
                S_TA_VAL: o_ambient_sensor_value <= iir_step(o_ambient_sensor_value,
                                                             i_ta_raw, len_reg); // [R11] [R15]
                S_TA:     o_ambient_temperature <= ta_clamp; // [R07] [R11]
                S_IR1_D:  o_ir1_filtered_reading <= iir_step(o_ir1_filtered_reading,
                                                             i_ir1_raw, len_reg); // [R12] [R15]
                S_TO1:    o_object_temperature_one <= obj_code(o_ambient_temperature,
                                                               o_ir1_filtered_reading,
                                                               i_obj_error); // [R09] [R12]
                S_IR2_D:  o_ir2_filtered_reading <= iir_step(o_ir2_filtered_reading,
                                                             i_ir2_raw, len_reg); // [R13] [R15]
                S_TO2:    o_object_temperature_two <= obj_code(o_ambient_temperature,
                                                               o_ir2_filtered_reading,
                                                               i_obj_error); // [R09] [R13]
                S_PWM:    o_pwm_word <= pwm_calc; // [R14]
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pwm_cnt_reg <= 10'h000;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 10'h001;
        end
    end

    // Between the switching points the level holds.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            relay_reg <= 1'b0;
        end else if (go_high) begin
            relay_reg <= 1'b1; // [R17] [R19] [R20] [R22]
        end else if (go_low) begin
            relay_reg <= 1'b0; // [R20] [R21]
        end
    end

    // One driver for pulse and relay; bus mode releases the pin.
    always_ff @(posedge i_clk) begin
        if (i_rst || !out_mode) begin
            sda_out_reg <= 1'b0; // [R05]
            sda_oe_reg  <= 1'b0;
        end else if (i_drive_open_drain) begin
            sda_out_reg <= 1'b0; // [R18]
            sda_oe_reg  <= !pin_level;
        end else begin
            sda_out_reg <= pin_level; // [R16] [R17] [R18]
            sda_oe_reg  <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_smbus_mode  <= 1'b0;
            o_relay_level <= 1'b0;
        end else begin
            o_smbus_mode  <= !out_mode;
            o_relay_level <= relay_reg;
        end
    end

    assign link.sda_out = sda_out_reg;
    assign link.sda_oe  = sda_oe_reg;

    wire unused_ok = &{1'b0, link.sda};
endmodule : irtm_device
`default_nettype wire

// ### irtm_host.sv
// Purpose: Host end: drives the bus request on the clock line for software.
// Assumes: AXI4-Lite slave, one write and one read in flight at most.
// Notes:   The data line is only sampled, never driven.
`default_nettype none
module irtm_host
    import irtm_pkg::*;
#(
    parameter int P_HOLD_CYC = REQ_HOLD_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    irtm_link_if.host        link,
    input  wire logic [3:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [3:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    initial begin
        if (P_HOLD_CYC < 2 || P_HOLD_CYC > 65535) begin
            $error("P_HOLD_CYC out of range");
        end
    end

    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        have_aw_reg;
    logic        have_w_reg;
    logic        pwmen_reg;
    logic        done_reg;
    logic [15:0] hold_cnt_reg;
    logic        sda_s1_reg;
    logic        sda_s2_reg;
    logic        scl_oe_reg;

    wire         do_wr    = have_aw_reg && have_w_reg && !o_bvalid;
    wire         wr_ctrl  = do_wr && (awaddr_reg == HOST_CTRL_ADDR) && wstrb_reg[0];
    wire         wr_stat  = do_wr && (awaddr_reg == HOST_STAT_ADDR) && wstrb_reg[0];
    wire         wr_ok    = do_wr && ((awaddr_reg == HOST_CTRL_ADDR) ||
                                      (awaddr_reg == HOST_STAT_ADDR));
    wire         busy     = hold_cnt_reg != 16'h0000;
    // No request while pulse output is known disabled. [R06]
    wire         start    = wr_ctrl && wdata_reg[CTRL_GO_BIT] && !busy &&
                            wdata_reg[CTRL_PWMEN_BIT];
    wire         finish   = hold_cnt_reg == 16'h0001;
    wire         rd_ctrl  = i_araddr == HOST_CTRL_ADDR;
    wire         rd_stat  = i_araddr == HOST_STAT_ADDR;
    wire  [31:0] stat_val = 32'(({sda_s2_reg, done_reg, busy}));
    wire  [31:0] ctrl_val = 32'({pwmen_reg, 1'b0});

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            have_aw_reg <= 1'b0;
            have_w_reg  <= 1'b0;
            awaddr_reg  <= 4'h0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            o_bvalid    <= 1'b0;
            o_bresp     <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                have_aw_reg <= 1'b1;
                awaddr_reg  <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                have_w_reg <= 1'b1;
                wdata_reg  <= i_wdata;
                wstrb_reg  <= i_wstrb;
            end
            if (do_wr) begin
                have_aw_reg <= 1'b0;
                have_w_reg  <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    assign o_awready = !have_aw_reg && !o_bvalid;
    assign o_wready  = !have_w_reg && !o_bvalid;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_ctrl ? ctrl_val : (rd_stat ? stat_val : 32'h0000_0000);
            o_rresp   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pwmen_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pwmen_reg <= wdata_reg[CTRL_PWMEN_BIT];
        end
    end

    // Completion is sticky; a finish in the clearing cycle wins.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            done_reg <= 1'b1;
        end else if (wr_stat && wdata_reg[STAT_DONE_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // Clock held low past the request time, else high. [R01] [R02]
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hold_cnt_reg <= 16'h0000;
            scl_oe_reg   <= 1'b0;
        end else if (start) begin
            hold_cnt_reg <= 16'(P_HOLD_CYC);
            scl_oe_reg   <= 1'b1;
        end else if (busy) begin
            hold_cnt_reg <= hold_cnt_reg - 16'h0001;
            scl_oe_reg   <= !finish;
        end
    end

    always_ff @(posedge i_clk) begin
        sda_s1_reg <= link.sda;
        sda_s2_reg <= sda_s1_reg;
    end

    assign link.scl_out = 1'b0;
    assign link.scl_oe  = scl_oe_reg;

    wire unused_ok = &{1'b0, link.scl, wdata_reg[31:2], wstrb_reg[3:1]};
endmodule : irtm_host
`default_nettype wire

// ### irtm_assertions.sv
// Purpose: Link checker for the bus request and the shared data pin.
// Assumes: Link lines, clock, reset and wake pulse as inputs.
// Notes:   Counters time the low clock line and the request.
`default_nettype none
module irtm_assertions
    import irtm_pkg::*;
#(
    parameter int P_REQ_CYC  = REQ_CYC,
    parameter int P_HOLD_CYC = REQ_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sleep_exit,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OFF_AT   = P_REQ_CYC + 7;
    logic [15:0] low_cnt_reg;
    logic [15:0] oe_cnt_reg;
    logic        off_reg;

    // Flags a request once the clock has been low OFF_AT cycles, until wake or reset.
    always_ff @(posedge i_clk) begin
        low_cnt_reg <= (i_rst || scl) ? 16'h0 : low_cnt_reg + 16'h1;
        oe_cnt_reg  <= (i_rst || !scl_oe) ? 16'h0 : oe_cnt_reg + 16'h1;
        off_reg     <= !(i_rst || i_sleep_exit) && (off_reg || low_cnt_reg == 16'(OFF_AT));
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    scl_drive_low_a: assert property (scl_oe |-> !scl_out && !scl)
        else $error("clock line driven but not low");
    req_low_hold_a: assert property ($rose(scl_oe) |-> (!scl)[*8])
        else $error("request low pulse cut short");
    req_long_enough_a: assert property ($fell(scl_oe) |-> oe_cnt_reg > 16'(P_REQ_CYC))
        else $error("request released before request time");
    req_release_a: assert property (oe_cnt_reg <= 16'(P_HOLD_CYC))
        else $error("request held too long");
    req_gap_a: assert property ($fell(scl_oe) |=> (!scl_oe)[*2])
        else $error("request raised again at once");
    pin_release_a: assert property (low_cnt_reg == 16'(OFF_AT) |-> !sda_oe)
        else $error("data pin still driven after request");
    pin_stays_off_a: assert property (off_reg |-> !sda_oe)
        else $error("data pin driven again after request");
    reset_quiet_a: assert property ($fell(i_rst) |-> !sda_oe)
        else $error("data pin driven at reset release");
endmodule : irtm_assertions
`default_nettype wire

// ### test_ir_thermo_output_mode_relay.sv
// Purpose: Bench for both ends joined by the link, host driven over AXI4-Lite.
// Assumes: Short request counts; zero filter length until the last test.
// Notes:   Expected values are worked out from the inputs.
`default_nettype none
module test_ir_thermo_output_mode_relay;
    import irtm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REQ = 20, HOLD = 30;
    localparam logic [15:0] RX [9] = '{16'h110, 16'h100, 16'h0f0, 16'h100, 16'h110,
                                       16'h100, 16'h0ff, 16'h100, 16'h101};
    localparam logic [8:0]  RL = 9'h133;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        sleep_exit = 1'b0, pwm_en = 1'b1, rel_sel = 1'b1, od = 1'b0, obj_err = 1'b0;
    logic [15:0] thr = 16'h3100, hys = 16'h0010, pmin = 16'h2000;
    logic [15:0] ta_ofs = 16'h0100, ta_raw = 16'h3100, ir1 = 16'h0, ir2 = 16'h0020;
    logic [15:0] amb, ir1_rd, ir2_rd, to1, to2;
    logic [9:0]  pwm_word;
    logic        smb, relay, awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          fails = 0, compares = 0;
    logic        dual = 1'b1;
    logic [2:0]  len = 3'h0;

    irtm_link_if link ();
    irtm_device #(.P_REQ_CYC(REQ)) irtm_device_inst (.i_clk(i_clk), .i_rst(i_rst),
        .link(link), .i_sleep_exit(sleep_exit), .i_pwm_enable(pwm_en),
        .i_relay_select(rel_sel), .i_drive_open_drain(od), .i_dual_ir(dual),
        .i_iir_len(len), .i_relay_threshold(thr), .i_relay_hysteresis(hys),
        .i_pwm_min(pmin), .i_ta_offset_raw(ta_ofs), .i_ta_raw(ta_raw), .i_ir1_raw(ir1),
        .i_ir2_raw(ir2), .i_obj_error(obj_err), .o_ambient_sensor_offset(),
        .o_ambient_sensor_value(), .o_ambient_temperature(amb),
        .o_ir1_filtered_reading(ir1_rd), .o_ir2_filtered_reading(ir2_rd),
        .o_object_temperature_one(to1), .o_object_temperature_two(to2),
        .o_pwm_word(pwm_word), .o_smbus_mode(smb), .o_relay_level(relay));
    irtm_host #(.P_HOLD_CYC(HOLD)) irtm_host_inst (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready));
    irtm_assertions #(.P_REQ_CYC(REQ), .P_HOLD_CYC(HOLD)) irtm_assertions_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_sleep_exit(sleep_exit), .scl_out(link.scl_out),
        .scl_oe(link.scl_oe), .sda_out(link.sda_out), .sda_oe(link.sda_oe),
        .scl(link.scl), .sda(link.sda));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge i_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    function automatic logic [15:0] obj(input logic [15:0] a, input logic [15:0] b,
                                        input logic e);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (e) return {1'b1, s[14:0]};
        return (s > 17'h07fff) ? TO_MAX_VALID : s[15:0];
    endfunction : obj

    task automatic measure(input logic [15:0] o, input logic [15:0] v, input logic [15:0] x,
                           input logic e);
        logic [16:0] s;
        logic [15:0] ea, e1;
        @(posedge i_clk);
        ta_ofs <= o;
        ta_raw <= v;
        ir1 <= x;
        obj_err <= e;
        repeat (30) @(posedge i_clk);
        s = {1'b0, v} - {1'b0, o};
        ea = (s < 17'(TA_LIN_MIN)) ? TA_LIN_MIN : (s > 17'(TA_LIN_MAX)) ? TA_LIN_MAX : s[15:0];
        e1 = obj(ea, x, e);
        s = {1'b0, e1} - {1'b0, pmin};
        check(amb, ea);
        check(ir1_rd, x);
        check(to1, e1);
        check(ir2_rd, ir2);
        check(to2, obj(ea, ir2, e));
        check(pwm_word, s[16] ? 10'h0 : s[15:6]);
    endtask : measure

    task automatic relay_step(input logic [15:0] x, input logic [15:0] h, input logic lv);
        @(posedge i_clk);
        ir1 <= x;
        hys <= h;
        repeat (30) @(posedge i_clk);
        check(relay, lv);
        check(link.sda, lv);
        check(link.sda_oe, od ? !lv : 1'b1);
    endtask : relay_step

    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        check(amb, TA_LIN_MIN);
        check(smb, 1'b0);
        i_rst <= 1'b0;
        measure(16'h0100, 16'h3100, 16'h0110, 1'b0);
        measure(16'h0100, 16'h0200, 16'h0010, 1'b0);
        measure(16'h0100, 16'h6000, 16'h4000, 1'b0);
        measure(16'h0100, 16'h3100, 16'h0110, 1'b1);
        measure(16'h0100, 16'h3100, 16'h0110, 1'b0);
        $display("test results done");
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clk);
            od <= p[0];
            for (int i = 0; i < 9; i++) relay_step(RX[i], (i < 5) ? 16'h0010 : 16'h0, RL[i]);
        end
        @(posedge i_clk);
        od <= 1'b0;
        rel_sel <= 1'b0;
        pmin <= 16'hffff;
        repeat (30) @(posedge i_clk);
        check(link.sda, 1'b0);
        rel_sel <= 1'b1;
        pmin <= 16'h2000;
        $display("test relay done");
        axi_wr(HOST_CTRL_ADDR, 32'h3, r);
        check(r, RESP_OKAY);
        do begin
            axi_rd(HOST_STAT_ADDR, d, r);
        end while (d[STAT_DONE_BIT] !== 1'b1);
        check(smb, 1'b1);
        check(link.sda_oe, 1'b0);
        check(d[STAT_SDA_BIT], 1'b1);
        measure(16'h0100, 16'h3100, 16'h00f0, 1'b0);
        check(link.sda_oe, 1'b0);
        axi_wr(HOST_STAT_ADDR, 32'h2, r);
        axi_wr(HOST_CTRL_ADDR, 32'h1, r);
        axi_rd(HOST_STAT_ADDR, d, r);
        check(d[2:0], 3'h4);
        axi_wr(4'h8, 32'h0, r);
        check(r, RESP_SLVERR);
        axi_rd(4'hc, d, r);
        check(r, RESP_SLVERR);
        @(posedge i_clk);
        sleep_exit <= 1'b1;
        @(posedge i_clk);
        sleep_exit <= 1'b0;
        repeat (30) @(posedge i_clk);
        check(smb, 1'b0);
        check(link.sda_oe, 1'b1);
        check(link.sda, relay);
        $display("test request done");
        pwm_en <= 1'b0;
        dual <= 1'b0;
        len <= 3'h1;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clk);
        check(smb, 1'b1);
        check(link.sda_oe, 1'b0);
        repeat (100) @(posedge i_clk);
        check(ir1_rd, 16'h00ef);
        check(ir2_rd, 16'h0000);
        $display("test power done");
        report_and_stop();
    end
endmodule : test_ir_thermo_output_mode_relay
`default_nettype wire
